// File: src/fast_parallel_config_slave.sv
/*
 * byte-wide passive configuration slave: samples the host's clock and byte bus,
 * drives the open-drain handshake lines and sequences initialization.
 * assumes all pins are asynchronous to core_clk and the link clock is far slower.
 */
// Functional notes
// - released status high means ready to load
// - capture byte on each rising link edge
// - raise completion one byte before end
// - user clock ignored during load, counts init
// - release init line when user mode begins
// - drop weak pull-ups in user mode
// - bit0 tri-stated in user mode by default
// - no minimum clock rate, pauses resume
// - drive chain enable out low when done
// - shared completion line starts init together
// - error pulls shared status low, resets chain
// - identical loading leaves chain output unused
// - request low aborts and restarts configuration
`default_nettype none
module fast_parallel_config_slave #(
	parameter int IMAGE_BYTES = fpp_config_pkg::DEFAULT_IMAGE_BYTES,
	parameter int STATUS_LOW_CYCLES = fpp_config_pkg::STATUS_LOW_CYCLES,
	parameter int USER_INIT_CYCLES = fpp_config_pkg::USER_INIT_CYCLES,
	parameter logic USE_USER_CLOCK = 1'b0,
	parameter logic BIT0_DRIVEN_IN_USER = 1'b0
) (
	// clocking
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// host link
	input wire logic config_clock,
	input wire logic [7:0] config_byte_bus,
	input wire logic config_request_n,
	input wire logic chain_enable_n,
	input wire logic user_init_clock,
	input wire logic checksum_error,
	// open-drain handshake lines: in, out, enable (low = driving)
	input wire logic config_status_n_in,
	output logic config_status_n_out,
	output logic config_status_n_oe_n,
	input wire logic config_complete_in,
	output logic config_complete_out,
	output logic config_complete_oe_n,
	output logic init_complete_out,
	output logic init_complete_oe_n,
	output logic chain_enable_out_n,
	// user side
	output logic [7:0] loadByte,
	output logic loadValid,
	input wire logic loadReady,
	output logic userMode,
	output logic weakPullupOn,
	output logic bit0OutEnable_n
);
	// ------------------------------------------------------------
	// pin synchronisers: three stages, a change counts when 2 and 3 agree
	// ------------------------------------------------------------
	localparam int NSYNC = 14;
	logic [NSYNC-1:0] s1, s2, s3, pinState;
	wire [NSYNC-1:0] rawPins = {config_clock, config_byte_bus, config_request_n,
		chain_enable_n, user_init_clock, config_status_n_in, config_complete_in};
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			pinState <= '1;
		end else if (clk_en) begin
			s1 <= rawPins;
			s2 <= s1;
			s3 <= s2;
			pinState <= (s2 ~^ s3) & s2 | ~(s2 ~^ s3) & pinState;
		end
	end
	logic prevClk, prevUclk;
	wire linkClk = pinState[13];
	wire [7:0] linkByte = s3[12:5];
	wire requestN = pinState[4];
	wire chainEnN = pinState[3];
	wire uclk = pinState[2];
	wire statusLine = pinState[1];
	wire completeLine = pinState[0];
	// edges found by the core clock; any pause of the link clock simply holds state
	wire clkRise = linkClk && !prevClk;
	wire clkFall = !linkClk && prevClk;
	wire uclkRise = uclk && !prevUclk;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	fpp_config_pkg::cfg_state_type state, next_state;
	logic [31:0] count;
	logic [31:0] byteCount;
	logic [1:0] fallCount;
	logic errorSeen;
	// status only counts as pulled low by others once we have seen it high
	logic statusArmed;
	wire bufReady;
	// the byte after early completion is never taken: it only serves serial schemes
	wire accepting = (state == fpp_config_pkg::ST_LOAD)
		&& !chainEnN && statusLine;
	wire takeByte = accepting && clkRise && bufReady;
	wire earlyDone = (byteCount == 32'(IMAGE_BYTES - 2));
	wire statusWaitDone = (count >= 32'(STATUS_LOW_CYCLES));
	wire delayDone = (count >= 32'(fpp_config_pkg::USER_CLOCK_ENABLE_DELAY_CYCLES));
	wire initDone = (count >= 32'(USER_INIT_CYCLES - 1)) && uclkRise;
	wire dropOut = earlyDone && takeByte;

	always_comb begin
		next_state = state;
		unique case (state)
			fpp_config_pkg::ST_RESET:
				if (statusWaitDone && requestN)
					next_state = fpp_config_pkg::ST_LOAD;
			fpp_config_pkg::ST_LOAD:
				if (takeByte && earlyDone)
					next_state = fpp_config_pkg::ST_FINAL;
			fpp_config_pkg::ST_FINAL:
				if (completeLine)
					next_state = fpp_config_pkg::ST_EDGES;
			fpp_config_pkg::ST_EDGES:
				// shared completion line: wait till every device has let go
				if (completeLine && fallCount == 2'(fpp_config_pkg::INIT_FALL_EDGES))
					next_state = USE_USER_CLOCK ? fpp_config_pkg::ST_DELAY
						: fpp_config_pkg::ST_USER;
			fpp_config_pkg::ST_DELAY:
				if (delayDone)
					next_state = fpp_config_pkg::ST_INIT;
			fpp_config_pkg::ST_INIT:
				if (initDone)
					next_state = fpp_config_pkg::ST_USER;
			fpp_config_pkg::ST_USER:
				next_state = state;
			fpp_config_pkg::ST_ERROR:
				// held until the host requests a fresh configuration
				next_state = state;
		endcase
		if (!requestN)
			next_state = fpp_config_pkg::ST_RESET;
		else if (errorSeen || (state != fpp_config_pkg::ST_RESET
			&& state != fpp_config_pkg::ST_ERROR && statusArmed && !statusLine))
			next_state = fpp_config_pkg::ST_ERROR;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= fpp_config_pkg::ST_RESET;
			count <= 32'h0000_0000;
			byteCount <= 32'h0000_0000;
			fallCount <= 2'h0;
			prevClk <= 1'b1;
			prevUclk <= 1'b1;
			errorSeen <= 1'b0;
			statusArmed <= 1'b0;
		end else if (clk_en) begin
			prevClk <= linkClk;
			prevUclk <= uclk;
			state <= next_state;
			if (state == fpp_config_pkg::ST_RESET || state == fpp_config_pkg::ST_ERROR)
				statusArmed <= 1'b0;
			else if (statusLine)
				statusArmed <= 1'b1;
			errorSeen <= checksum_error && accepting;
			if (next_state != state)
				count <= 32'h0000_0000;
			else if (state != fpp_config_pkg::ST_INIT || uclkRise)
				count <= count + 32'h0000_0001;
			if (state == fpp_config_pkg::ST_RESET)
				byteCount <= 32'h0000_0000;
			else if (takeByte)
				byteCount <= byteCount + 32'h0000_0001;
			if (state != fpp_config_pkg::ST_EDGES)
				fallCount <= 2'h0;
			else if (clkFall && fallCount != 2'(fpp_config_pkg::INIT_FALL_EDGES))
				fallCount <= fallCount + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// byte path through the two-entry buffer
	// ------------------------------------------------------------
	fpp_config_pkg::cfg_word_type inWord, outWord;
	wire outValid;
	assign inWord.data = linkByte;
	assign inWord.last = earlyDone;
	word_skid_buffer #(
		.WIDTH($bits(fpp_config_pkg::cfg_word_type))
	) byteBuffer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.inData(inWord),
		.inValid(takeByte),
		.inReady(bufReady),
		.outData(outWord),
		.outValid(outValid),
		.outReady(loadReady)
	);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	wire inUser = (next_state == fpp_config_pkg::ST_USER);
	wire holdStatus = (next_state == fpp_config_pkg::ST_RESET)
		|| (next_state == fpp_config_pkg::ST_ERROR);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			config_status_n_out <= 1'b0;
			config_status_n_oe_n <= 1'b0;
			config_complete_out <= 1'b0;
			config_complete_oe_n <= 1'b0;
			init_complete_out <= 1'b0;
			init_complete_oe_n <= 1'b0;
			chain_enable_out_n <= 1'b1;
			loadByte <= 8'h00;
			loadValid <= 1'b0;
			userMode <= 1'b0;
			weakPullupOn <= 1'b1;
			bit0OutEnable_n <= 1'b1;
		end else if (clk_en) begin
			config_status_n_oe_n <= !holdStatus;
			config_complete_oe_n <= (next_state == fpp_config_pkg::ST_FINAL)
				|| (next_state == fpp_config_pkg::ST_EDGES)
				|| (next_state == fpp_config_pkg::ST_DELAY)
				|| (next_state == fpp_config_pkg::ST_INIT) || inUser;
			init_complete_oe_n <= inUser;
			// with identical loading the next stage is simply left unconnected
			if (holdStatus)
				chain_enable_out_n <= 1'b1;
			else if (dropOut)
				chain_enable_out_n <= 1'b0;
			loadByte <= outWord.data;
			loadValid <= outValid && loadReady;
			userMode <= inUser;
			weakPullupOn <= !inUser;
			bit0OutEnable_n <= !(inUser && BIT0_DRIVEN_IN_USER);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence seqLastTaken;
		takeByte && earlyDone;
	endsequence
	a_ignore_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
		chainEnN |-> !takeByte) else $error("byte taken while chain disabled");
	a_early_complete: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && takeByte && earlyDone && state == fpp_config_pkg::ST_LOAD
		&& requestN && !errorSeen && statusLine |=> config_complete_oe_n)
		else $error("completion not released one byte early");
	a_chain_out: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && requestN && !errorSeen && statusLine ##0 seqLastTaken
		|=> !chain_enable_out_n) else $error("chain output not driven low");
	a_request_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !requestN |=> state == fpp_config_pkg::ST_RESET && !config_status_n_oe_n)
		else $error("request did not abort");
	a_error_status: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && errorSeen && requestN |=> !config_status_n_oe_n)
		else $error("error did not pull status low");
	a_init_release: assert property (@(posedge core_clk) disable iff (sys_rst)
		init_complete_oe_n |-> userMode) else $error("init released outside user mode");
	a_pullups_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		userMode |-> !weakPullupOn) else $error("pull-ups kept in user mode");
	a_bit0_tristate: assert property (@(posedge core_clk) disable iff (sys_rst)
		!BIT0_DRIVEN_IN_USER |-> bit0OutEnable_n) else $error("bit0 driven in user mode");
	a_edges_needed: assert property (@(posedge core_clk) disable iff (sys_rst)
		state == fpp_config_pkg::ST_EDGES && fallCount < 2'h2 |=>
		state != fpp_config_pkg::ST_USER && state != fpp_config_pkg::ST_DELAY)
		else $error("init began before two falling edges");
	a_pause_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
		!clkRise && state != fpp_config_pkg::ST_RESET |=> $stable(byteCount))
		else $error("byte count moved without edge");
endmodule
`default_nettype wire

// File: src/fpp_config_pkg.sv
/*
 * constants and carrier types for the byte-wide passive configuration slave.
 * assumes one core clock at 100 MHz; all link pins arrive asynchronously.
 */
`default_nettype none
package fpp_config_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_MHZ = 100;
	localparam int CORE_PERIOD_NS = 1000 / CORE_CLK_MHZ;
	// least config_status_n low time after a request, in ns
	localparam int STATUS_LOW_NS = 45000;
	localparam int STATUS_LOW_CYCLES = (STATUS_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// user_clock_enable_delay, in ns (four slow link periods)
	localparam int USER_CLOCK_ENABLE_DELAY_NS = 4 * 125;
	localparam int USER_CLOCK_ENABLE_DELAY_CYCLES =
		(USER_CLOCK_ENABLE_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int USER_INIT_CYCLES = 3192;
	localparam int INIT_FALL_EDGES = 2;
	localparam int DEFAULT_IMAGE_BYTES = 16;
	localparam logic [31:0] WAIT_WIDTH = 32'h0000_0020;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} cfg_word_type;

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_LOAD = 3'b001,
		ST_FINAL = 3'b010,
		ST_EDGES = 3'b011,
		ST_DELAY = 3'b100,
		ST_INIT = 3'b101,
		ST_USER = 3'b110,
		ST_ERROR = 3'b111
	} cfg_state_type;
endpackage
`default_nettype wire

// File: src/word_skid_buffer.sv
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes both sides share core_clk and the freeze enable.
 */
`default_nettype none
module word_skid_buffer #(
	parameter int WIDTH = 9
) (
	// clocking
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// fill side
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	// drain side
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	logic [WIDTH-1:0] slot [2];
	logic rdPtr;
	logic wrPtr;
	logic [1:0] count;
	wire doWrite = inValid && inReady;
	wire doRead = outValid && outReady;

	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = slot[rdPtr];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdPtr <= 1'b0;
			wrPtr <= 1'b0;
			count <= 2'h0;
		end else if (clk_en) begin
			if (doWrite) begin
				slot[wrPtr] <= inData;
				wrPtr <= ~wrPtr;
			end
			if (doRead)
				rdPtr <= ~rdPtr;
			count <= count + {1'b0, doWrite} - {1'b0, doRead};
		end
	end
endmodule
`default_nettype wire

// File: verification/cfg_host_model.sv
/*
 * behavioural host that streams configuration bytes over the link pins.
 * assumes resolved status and completion line levels from the bench.
 */
`default_nettype none
module cfg_host_model (
	// control
	input wire logic go,
	input wire logic [7:0] firstByte,
	input wire logic [7:0] maxBytes,
	// link
	input wire logic statusLine,
	input wire logic completeLine,
	output logic linkClk,
	output logic [7:0] linkByte,
	output logic busy,
	output logic [7:0] sent
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		linkClk = 1'b0;
		linkByte = 8'h00;
		busy = 1'b0;
		sent = 8'h00;
	end
	always @(posedge go) begin
		busy = 1'b1;
		sent = 8'h00;
		while (statusLine !== 1'b1) #10;
		while (completeLine !== 1'b1 && sent < maxBytes) begin
			linkByte = firstByte + sent;
			#40 linkClk = 1'b1;
			#62.5 linkClk = 1'b0;
			// hold time over: show the inverse so stale data is never mistaken
			linkByte = ~linkByte;
			#22.5 sent = sent + 8'h01;
			if (sent == 8'h02) #3000;
		end
		if (completeLine === 1'b1) begin
			repeat (2) begin
				#62.5 linkClk = 1'b1;
				#62.5 linkClk = 1'b0;
			end
		end
		busy = 1'b0;
	end
endmodule
`default_nettype wire

// File: verification/fast_parallel_config_slave_test.sv
/*
 * self-checking bench: host model on the link, bench pull-ups on open-drain lines.
 * assumes shortened counts via parameters; user clock option left off.
 */
`default_nettype none
module fast_parallel_config_slave_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NB = 4;
	logic coreClk = 1'b0, sysRst = 1'b1, requestN = 1'b1, chainEnN = 1'b1;
	logic userClk = 1'b0, csumErr = 1'b0, loadReady = 1'b1, go = 1'b0;
	logic statusOut, statusOeN, completeOut, completeOeN, initOut, initOeN;
	logic chainOutN, loadValid, userMode, pullupOn, bit0OeN, linkClk, busy;
	logic statusLine, completeLine, initLine;
	logic [7:0] loadByte, linkByte, sent, firstByte = 8'h00, maxBytes = 8'h00;
	logic [7:0] rxq[$];
	int error_cnt = 0;
	int checked = 0;
	// ------------------------------------------------------------
	// wiring
	// ------------------------------------------------------------
	// pull-ups: a released line reads high
	assign statusLine = statusOeN ? 1'b1 : statusOut;
	assign completeLine = completeOeN ? 1'b1 : completeOut;
	assign initLine = initOeN ? 1'b1 : initOut;
	always #5 coreClk = ~coreClk;
	always #250 userClk = ~userClk;
	always @(posedge coreClk) if (loadValid === 1'b1) rxq.push_back(loadByte);
	fast_parallel_config_slave #(.IMAGE_BYTES(NB), .STATUS_LOW_CYCLES(20),
		.USER_INIT_CYCLES(8)) i_fast_parallel_config_slave (
		.core_clk(coreClk), .sys_rst(sysRst), .clk_en(1'b1),
		.config_clock(linkClk), .config_byte_bus(linkByte),
		.config_request_n(requestN), .chain_enable_n(chainEnN),
		.user_init_clock(userClk), .checksum_error(csumErr),
		.config_status_n_in(statusLine), .config_status_n_out(statusOut),
		.config_status_n_oe_n(statusOeN), .config_complete_in(completeLine),
		.config_complete_out(completeOut), .config_complete_oe_n(completeOeN),
		.init_complete_out(initOut), .init_complete_oe_n(initOeN),
		.chain_enable_out_n(chainOutN), .loadByte(loadByte), .loadValid(loadValid),
		.loadReady(loadReady), .userMode(userMode), .weakPullupOn(pullupOn),
		.bit0OutEnable_n(bit0OeN));
	cfg_host_model i_cfg_host_model (.go(go), .firstByte(firstByte),
		.maxBytes(maxBytes), .statusLine(statusLine), .completeLine(completeLine),
		.linkClk(linkClk), .linkByte(linkByte), .busy(busy), .sent(sent));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task check_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task check_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task run_host(input logic [7:0] first, input logic [7:0] maxb);
		firstByte <= first;
		maxBytes <= maxb;
		go <= 1'b1;
		@(posedge coreClk);
		go <= 1'b0;
		@(posedge coreClk);
		for (int i = 0; i < 2000 && busy === 1'b1; i++) @(posedge coreClk);
	endtask
	task wait_status;
		for (int i = 0; i < 80 && statusLine !== 1'b1; i++) @(posedge coreClk);
	endtask
	// a request pulse well over the least low width
	task restart;
		requestN <= 1'b0;
		repeat (60) @(posedge coreClk);
		requestN <= 1'b1;
		wait_status();
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_release;
		check_flag(statusLine, 1'b0);
		wait_status();
		check_flag(statusLine, 1'b1);
		check_flag(chainOutN, 1'b1);
		check_flag(initLine, 1'b0);
	endtask
	task t_disabled;
		rxq.delete();
		run_host(8'h10, 8'h03);
		repeat (10) @(posedge coreClk);
		check_byte(8'(rxq.size()), 8'h00);
		check_flag(completeLine, 1'b0);
	endtask
	task t_load(input logic [7:0] first);
		chainEnN <= 1'b0;
		rxq.delete();
		fork
			run_host(first, 8'h10);
			begin
				// receiver stalls while the second byte is due
				repeat (20) @(posedge coreClk);
				loadReady <= 1'b0;
				repeat (8) @(posedge coreClk);
				loadReady <= 1'b1;
			end
		join
		check_byte(sent, 8'(NB - 1));
		check_byte(8'(rxq.size()), 8'(NB - 1));
		foreach (rxq[i]) check_byte(rxq[i], first + 8'(i));
		check_flag(chainOutN, 1'b0);
		for (int i = 0; i < 100 && userMode !== 1'b1; i++) @(posedge coreClk);
		check_flag(userMode, 1'b1);
		check_flag(initLine, 1'b1);
		check_flag(pullupOn, 1'b0);
		check_flag(bit0OeN, 1'b1);
	endtask
	task t_abort;
		requestN <= 1'b0;
		repeat (60) @(posedge coreClk);
		check_flag(userMode, 1'b0);
		check_flag(statusLine, 1'b0);
		check_flag(completeLine, 1'b0);
		requestN <= 1'b1;
		wait_status();
		check_flag(statusLine, 1'b1);
	endtask
	task t_error;
		rxq.delete();
		fork
			run_host(8'h40, 8'h06);
			begin
				for (int i = 0; i < 500 && rxq.size() == 0; i++) @(posedge coreClk);
				csumErr <= 1'b1;
				repeat (8) @(posedge coreClk);
				csumErr <= 1'b0;
			end
		join
		check_flag(statusLine, 1'b0);
		check_flag(completeLine, 1'b0);
		check_byte(sent, 8'h06);
		restart();
		check_flag(statusLine, 1'b1);
		t_load(8'h70);
	endtask
	initial begin
		repeat (16) @(posedge coreClk);
		sysRst <= 1'b0;
		@(posedge coreClk);
		t_release();
		t_disabled();
		t_load(8'ha5);
		t_abort();
		t_error();
		give_verdict();
	end
	initial begin
		#300000;
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
